// file: src/wss_pkg.sv
// Shared constants, types and helper functions of the wheel sensor signal synthesiser
package wss_pkg;
  // Structure
  localparam int CHANNELS = 4;
  localparam int DAC_W = 12;
  localparam int DELTA_W = 16;
  localparam int ACC_W = 22;
  localparam int IDX_W = 16;
  localparam int TABLE_ADDR_W = 6;
  localparam int VALUE_W = 16;
  localparam int TEETH_W = 8;
  localparam int SHIFT_W = 4;
  localparam int PWM_W = 16;
  localparam int NUM_W = 80;
  localparam int DEN_W = 50;
  localparam int TICK_W = 16;
  localparam int LAMBDA_W = 17;
  // Timing
  localparam int CLK_FREQ_MHZ = 100;
  localparam real PASSIVE_CYCLE_US = 7.0;
  localparam real ACTIVE_CYCLE_US = 4.5;
  localparam int PASSIVE_CYCLE_CLKS = $rtoi(PASSIVE_CYCLE_US * CLK_FREQ_MHZ);
  localparam int ACTIVE_CYCLE_CLKS = $rtoi(ACTIVE_CYCLE_US * CLK_FREQ_MHZ);
  localparam int PASSIVE_CYCLE_NS = $rtoi(PASSIVE_CYCLE_US * 1000.0);
  localparam int ACTIVE_CYCLE_NS = $rtoi(ACTIVE_CYCLE_US * 1000.0);
  // Frequency arithmetic
  localparam longint NS_PER_S = 64'd1000000000;
  localparam longint TWO_PI_MILLI = 64'd6283;
  localparam longint WHEEL_DEN_SCALE = 64'd1000000;
  localparam logic [1:0] EDGE_FACTOR_DUAL = 2'h2;
  localparam logic [1:0] EDGE_FACTOR_TRAILING = 2'h1;
  localparam logic [DAC_W-1:0] DAC_MID = 12'h800;
  // Address decode
  localparam int ADDR_W = 24;
  localparam int DECODE_LSB = 16;
  localparam logic [ADDR_W-1:0] BASE_ADDR_ID1 = 24'h580000;
  localparam logic [ADDR_W-1:0] BASE_ADDR_ID2 = 24'h050000;

  typedef enum logic [1:0] {
    MODE_WHEEL = 2'b00,
    MODE_FREQ = 2'b01,
    MODE_EXPERT = 2'b10
  } freq_mode_e;

  typedef enum logic {
    dual_edge_sensor_type = 1'b0,
    trailing_edge_sensor_type = 1'b1
  } sensor_type_e;

  typedef enum logic [1:0] {
    CFG_IDLE = 2'b00,
    CFG_START = 2'b01,
    CFG_WAIT = 2'b10
  } cfg_state_e;

  // Quarter wave magnitudes, 2047 * sin(k * pi / 32)
  function automatic logic [DAC_W-1:0] quarter_mag(input logic [4:0] k);
    case (k)
      5'h00: quarter_mag = 12'h000;
      5'h01: quarter_mag = 12'h0c9;
      5'h02: quarter_mag = 12'h18f;
      5'h03: quarter_mag = 12'h252;
      5'h04: quarter_mag = 12'h30f;
      5'h05: quarter_mag = 12'h3c5;
      5'h06: quarter_mag = 12'h471;
      5'h07: quarter_mag = 12'h513;
      5'h08: quarter_mag = 12'h5a7;
      5'h09: quarter_mag = 12'h62e;
      5'h0a: quarter_mag = 12'h6a6;
      5'h0b: quarter_mag = 12'h70d;
      5'h0c: quarter_mag = 12'h763;
      5'h0d: quarter_mag = 12'h7a7;
      5'h0e: quarter_mag = 12'h7d8;
      5'h0f: quarter_mag = 12'h7f5;
      default: quarter_mag = 12'h7ff;
    endcase
  endfunction

  // Full sine table entry by quadrant symmetry
  function automatic logic [DAC_W-1:0] sine_code(input logic [TABLE_ADDR_W-1:0] a);
    logic [4:0] k;
    logic [DAC_W-1:0] mag;
    k = a[4] ? 5'(5'h10 - {1'b0, a[3:0]}) : {1'b0, a[3:0]};
    mag = quarter_mag(k);
    sine_code = a[5] ? DAC_MID - mag : DAC_MID + mag;
  endfunction
endpackage

// file: src/pwm_pair_if.sv
// Carrier between the synthesiser and one pair of PWM counters
`timescale 1ns/1ps
`default_nettype none
interface pwm_pair_if;
  logic tick;
  logic edge_pulse;
  logic [wss_pkg::PWM_W-1:0] high_max;
  logic [wss_pkg::PWM_W-1:0] low_min;
  logic pwm_out;
  modport ctrl (output tick, output edge_pulse, output high_max, output low_min, input pwm_out);
  modport pair (input tick, input edge_pulse, input high_max, input low_min, output pwm_out);
endinterface
`default_nettype wire

// file: src/pwm_pair.sv
// One digital output channel: a period counter and a high phase counter
`timescale 1ns/1ps
`default_nettype none
module pwm_pair (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Channel link
  pwm_pair_if.pair bus
);
  import wss_pkg::*;

  logic [PWM_W:0] period_cnt_reg;
  logic [PWM_W:0] high_cnt_reg;
  logic pwm_reg;

  // High phase: maximum unless the minimum low phase would be cut
  function automatic logic [PWM_W:0] high_len(input logic [PWM_W:0] per, input logic [PWM_W-1:0] hmax,
                                              input logic [PWM_W-1:0] lmin);
    logic [PWM_W+1:0] lim;
    logic [PWM_W+1:0] lowm;
    lim = {2'b00, hmax} + 18'h1;
    lowm = {2'b00, lmin} + 18'h1;
    if ({1'b0, per} >= lim + lowm)
      high_len = lim[PWM_W:0];
    else if ({1'b0, per} > lowm)
      high_len = per - lowm[PWM_W:0];
    else
      high_len = 17'h1;
  endfunction

  // Counter pair; the last measured period predicts the next one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      period_cnt_reg <= '1;
      high_cnt_reg <= '0;
      pwm_reg <= 1'b0;
    end else if (bus.edge_pulse) begin
      // The tick that carries this pulse already counts toward the next period
      period_cnt_reg <= 17'h1;
      high_cnt_reg <= high_len(period_cnt_reg, bus.high_max, bus.low_min); // R15 R16 R17
      pwm_reg <= 1'b1;
    end else if (bus.tick) begin
      if (period_cnt_reg != '1)
        period_cnt_reg <= period_cnt_reg + 17'h1;
      if (high_cnt_reg > 17'h1) begin
        high_cnt_reg <= high_cnt_reg - 17'h1; // R15
      end else begin
        high_cnt_reg <= '0;
        pwm_reg <= 1'b0;
      end
    end
  end

  assign bus.pwm_out = pwm_reg;
endmodule // pwm_pair
`default_nettype wire

// file: src/delta_div.sv
// Sequential restoring divider that turns a frequency request into an increment
`timescale 1ns/1ps
`default_nettype none
module delta_div #(
  parameter int NW = 80,
  parameter int DW = 50,
  parameter int QW = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Request
  input wire logic start,
  input wire logic [NW-1:0] num,
  input wire logic [DW-1:0] den,
  // Answer
  output logic done,
  output logic [QW-1:0] quo
);
  logic [NW-1:0] num_reg;
  logic [NW-1:0] q_reg;
  logic [DW:0] rem_reg;
  logic [DW-1:0] den_reg;
  logic [7:0] step_reg;
  logic run_reg;
  logic [DW+1:0] trial;

  assign trial = {rem_reg, num_reg[NW-1]};

  // One quotient bit per clock; result saturates to the increment width
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      num_reg <= '0;
      q_reg <= '0;
      rem_reg <= '0;
      den_reg <= '0;
      step_reg <= '0;
      run_reg <= 1'b0;
      done <= 1'b0;
      quo <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        num_reg <= num;
        den_reg <= den;
        rem_reg <= '0;
        q_reg <= '0;
        step_reg <= 8'(NW);
        run_reg <= 1'b1;
      end else if (run_reg) begin
        num_reg <= num_reg << 1;
        if (trial >= {2'b00, den_reg}) begin
          rem_reg <= (DW+1)'(trial - {2'b00, den_reg});
          q_reg <= {q_reg[NW-2:0], 1'b1};
        end else begin
          rem_reg <= trial[DW:0];
          q_reg <= {q_reg[NW-2:0], 1'b0};
        end
        step_reg <= step_reg - 8'h1;
        if (step_reg == 8'h1) begin
          run_reg <= 1'b0;
          done <= 1'b1;
          if (den_reg == '0 || q_reg[NW-2:QW-1] != '0)
            quo <= '1;
          else
            quo <= {q_reg[QW-2:0], trial >= {2'b00, den_reg}};
        end
      end
    end
  end
endmodule // delta_div
`default_nettype wire

// file: src/wheel_sensor_signal_synth.sv
// Wheel speed sensor signal synthesiser: passive sine outputs and active PWM outputs
`timescale 1ns/1ps
`default_nettype none
// Contract
// R01: Passive: one sine entry per constant sample period
// R02: Advance table index by delta after each sample
// R03: Sample period is 2^(shift+1)-1 processor cycles
// R04: Passive processor cycle is 7 us
// R05: Four analog channels of 12-bit codes
// R06: Active: 22-bit accumulator, overflow marks tooth
// R07: PWM period from accumulator width, delta, factor
// R08: Dual-edge type pulses at every tooth edge
// R09: Trailing-edge type pulses on trailing edge only
// R10: Wheel, frequency or expert mode; expert uses delta
// R11: Wheel mode derives frequency from speed, radius, teeth
// R12: Frequency mode uses requested hertz
// R13: Decode one of two base addresses by identifier
// R14: Eight counters, one pair per digital output
// R15: High phase at most (high param + 1) cycles
// R16: Low phase at least (low param + 1) cycles; code gives period - 1 when the period is not longer than that
// R17: Keep frequency, shorten high only for low minimum
// R18: Table index wraps modulo the table length
module wheel_sensor_signal_synth (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Common configuration
  input wire wss_pkg::freq_mode_e freq_mode,
  input wire logic sensor_active,
  input wire wss_pkg::sensor_type_e sensor_type,
  input wire logic [wss_pkg::SHIFT_W-1:0] sample_period_shift,
  input wire logic [wss_pkg::TEETH_W-1:0] teeth_count,
  input wire logic cfg_load,
  output logic cfg_busy,
  // Per wheel settings
  input wire logic [wss_pkg::CHANNELS-1:0][wss_pkg::VALUE_W-1:0] wheel_value,
  input wire logic [wss_pkg::CHANNELS-1:0][wss_pkg::VALUE_W-1:0] wheel_radius,
  input wire logic [wss_pkg::CHANNELS-1:0][wss_pkg::DAC_W-1:0] amplitude,
  input wire logic [wss_pkg::CHANNELS-1:0][wss_pkg::PWM_W-1:0] pwm_high_max_param,
  input wire logic [wss_pkg::CHANNELS-1:0][wss_pkg::PWM_W-1:0] pwm_low_min_param,
  // Board decode
  input wire logic [wss_pkg::ADDR_W-1:0] bus_addr,
  input wire logic board_id_sel,
  output logic board_selected,
  // Signal outputs
  output logic [wss_pkg::CHANNELS-1:0][wss_pkg::DAC_W-1:0] dac_code,
  output logic dac_strobe,
  output logic [wss_pkg::CHANNELS-1:0] pwm_out
);
  import wss_pkg::*;

  logic [TICK_W-1:0] tick_cnt_reg;
  logic [TICK_W-1:0] tick_limit;
  logic cyc_tick;
  logic [LAMBDA_W-1:0] lambda_val;
  logic [LAMBDA_W-1:0] lam_cnt_reg;
  logic sample_en;
  cfg_state_e cfg_state_reg;
  logic [1:0] cfg_ch_reg;
  logic [CHANNELS-1:0][DELTA_W-1:0] delta_reg;
  logic [NUM_W-1:0] div_num;
  logic [DEN_W-1:0] div_den;
  logic div_done;
  logic [DELTA_W-1:0] div_quo;
  logic [CHANNELS-1:0][IDX_W-1:0] idx_reg;
  logic [CHANNELS-1:0][ACC_W-1:0] acc_reg;
  logic [CHANNELS-1:0][ACC_W:0] acc_sum;
  logic [CHANNELS-1:0] tooth_ovf;
  logic [CHANNELS-1:0] half_cross;
  logic [CHANNELS-1:0] edge_pulse;
  logic [ADDR_W-1:0] base_addr;

  // Scale a table entry around mid code by the channel amplitude
  function automatic logic [DAC_W-1:0] scale_code(input logic [DAC_W-1:0] code, input logic [DAC_W-1:0] amp);
    logic signed [DAC_W:0] diff;
    logic signed [2*DAC_W+1:0] prod;
    diff = $signed({1'b0, code}) - $signed({1'b0, DAC_MID});
    prod = diff * $signed({1'b0, amp});
    scale_code = DAC_W'($signed({1'b0, DAC_MID}) + (prod >>> DAC_W));
  endfunction

  // Processor cycle divider: 7 us passive, 4.5 us active
  assign tick_limit = sensor_active ? TICK_W'(ACTIVE_CYCLE_CLKS - 1) : TICK_W'(PASSIVE_CYCLE_CLKS - 1); // R04 R06
  assign cyc_tick = (tick_cnt_reg >= tick_limit); // No long wrap when the kind changes mid-count

  always_ff @(posedge clk) begin
    if (sys_rst || cyc_tick)
      tick_cnt_reg <= '0;
    else
      tick_cnt_reg <= tick_cnt_reg + 16'h1;
  end

  // Sample period of lambda processor cycles
  assign lambda_val = LAMBDA_W'((17'h1 << ({1'b0, sample_period_shift} + 5'h1)) - 17'h1); // R03
  assign sample_en = cyc_tick && !sensor_active && (lam_cnt_reg >= lambda_val - 17'h1); // R01 R03

  always_ff @(posedge clk) begin
    if (sys_rst || sensor_active)
      lam_cnt_reg <= '0;
    else if (sample_en)
      lam_cnt_reg <= '0;
    else if (cyc_tick)
      lam_cnt_reg <= lam_cnt_reg + 17'h1;
  end

  // Dividend and divisor of the increment for the channel in conversion
  always_comb begin
    logic [NUM_W-1:0] base_factor;
    logic [NUM_W-1:0] val;
    base_factor = '0;
    val = NUM_W'(wheel_value[cfg_ch_reg]);
    div_num = '0;
    div_den = '0;
    if (sensor_active)
      base_factor = NUM_W'(ACTIVE_CYCLE_NS) << ACC_W; // R07
    else
      base_factor = (NUM_W'(lambda_val) * NUM_W'(PASSIVE_CYCLE_NS)) << IDX_W;
    if (freq_mode == MODE_WHEEL) begin
      // Edge factor cancels between pulse rate and increment here
      div_num = NUM_W'(base_factor * val * NUM_W'(teeth_count)); // R11
      div_den = DEN_W'(TWO_PI_MILLI * WHEEL_DEN_SCALE * 64'(wheel_radius[cfg_ch_reg]));
    end else begin
      div_num = NUM_W'(base_factor * val); // R12
      if (sensor_active && sensor_type == dual_edge_sensor_type)
        div_den = DEN_W'(NS_PER_S * 64'(EDGE_FACTOR_DUAL)); // R07 R08
      else if (sensor_active)
        div_den = DEN_W'(NS_PER_S * 64'(EDGE_FACTOR_TRAILING)); // R07 R09
      else
        div_den = DEN_W'(NS_PER_S);
    end
  end

  delta_div #(
    .NW(NUM_W),
    .DW(DEN_W),
    .QW(DELTA_W)
  ) u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(cfg_state_reg == CFG_START),
    .num(div_num),
    .den(div_den),
    .done(div_done),
    .quo(div_quo)
  );

  // Increment loading: all channels at once in expert mode, else channel by channel through the divider
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_state_reg <= CFG_IDLE;
      cfg_ch_reg <= '0;
      delta_reg <= '0;
    end else begin
      case (cfg_state_reg)
        CFG_IDLE: begin
          if (cfg_load && freq_mode == MODE_EXPERT) begin
            delta_reg <= wheel_value; // R10
          end else if (cfg_load) begin
            cfg_ch_reg <= '0;
            cfg_state_reg <= CFG_START;
          end
        end
        CFG_START: cfg_state_reg <= CFG_WAIT;
        CFG_WAIT: begin
          if (div_done) begin
            delta_reg[cfg_ch_reg] <= div_quo;
            cfg_ch_reg <= cfg_ch_reg + 2'h1;
            cfg_state_reg <= (cfg_ch_reg == 2'(CHANNELS - 1)) ? CFG_IDLE : CFG_START;
          end
        end
        default: cfg_state_reg <= CFG_IDLE;
      endcase
    end
  end

  assign cfg_busy = (cfg_state_reg != CFG_IDLE);

  // Passive: output the current entry, then step the index with wrap
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      idx_reg <= '0;
      dac_code <= {CHANNELS{DAC_MID}};
      dac_strobe <= 1'b0;
    end else begin
      dac_strobe <= sample_en;
      if (sensor_active) begin
        dac_code <= {CHANNELS{DAC_MID}};
      end else if (sample_en) begin
        for (int c = 0; c < CHANNELS; c++) begin
          dac_code[c] <= scale_code(sine_code(idx_reg[c][IDX_W-1 -: TABLE_ADDR_W]), amplitude[c]); // R01 R05
          idx_reg[c] <= idx_reg[c] + delta_reg[c]; // R02 R18
        end
      end
    end
  end

  // Active: accumulator overflow and half way crossing give tooth edges
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      acc_sum[c] = {1'b0, acc_reg[c]} + (ACC_W+1)'(delta_reg[c]);
      tooth_ovf[c] = acc_sum[c][ACC_W]; // R06
      half_cross[c] = !acc_reg[c][ACC_W-1] && acc_sum[c][ACC_W-1] && !acc_sum[c][ACC_W];
      edge_pulse[c] = cyc_tick && sensor_active &&
                      (tooth_ovf[c] || (sensor_type == dual_edge_sensor_type && half_cross[c])); // R08 R09
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !sensor_active) begin
      acc_reg <= '0;
    end else if (cyc_tick) begin
      for (int c = 0; c < CHANNELS; c++)
        acc_reg[c] <= acc_sum[c][ACC_W-1:0]; // R06 R07
    end
  end

  // Eight counters, a pair for each digital output
  for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
    pwm_pair_if pif ();
    assign pif.tick = cyc_tick && sensor_active;
    assign pif.edge_pulse = edge_pulse[g];
    assign pif.high_max = pwm_high_max_param[g];
    assign pif.low_min = pwm_low_min_param[g];
    pwm_pair u_pair ( // R14
      .clk(clk),
      .sys_rst(sys_rst),
      .bus(pif.pair)
    );
    assign pwm_out[g] = pif.pwm_out;
  end

  // Board address decode by identifier
  assign base_addr = board_id_sel ? BASE_ADDR_ID2 : BASE_ADDR_ID1;

  always_ff @(posedge clk) begin
    if (sys_rst)
      board_selected <= 1'b0;
    else
      board_selected <= (bus_addr[ADDR_W-1:DECODE_LSB] == base_addr[ADDR_W-1:DECODE_LSB]); // R13
  end

  // Checking helpers: clocks since the last processor tick, ticks between samples
  logic [TICK_W-1:0] gap_reg;
  logic [LAMBDA_W-1:0] ticks_reg;

  always_ff @(posedge clk) begin
    if (sys_rst || cyc_tick)
      gap_reg <= 16'h1;
    else
      gap_reg <= gap_reg + 16'h1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst || sensor_active || sample_en)
      ticks_reg <= '0;
    else if (cyc_tick)
      ticks_reg <= ticks_reg + 17'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  passive_cycle_a: assert property (cyc_tick && !sensor_active && $stable(sensor_active) && gap_reg > 16'h1 // R04
    |-> gap_reg == 16'(PASSIVE_CYCLE_CLKS)) else $error("passive cycle not 7 us");
  active_cycle_a: assert property (cyc_tick && sensor_active && $stable(sensor_active) && gap_reg > 16'h1 // R06
    |-> gap_reg == 16'(ACTIVE_CYCLE_CLKS)) else $error("active cycle not 4.5 us");
  sample_period_a: assert property (sample_en && $stable(sample_period_shift) // R03
    |-> ticks_reg + 17'h1 >= lambda_val) else $error("sample period shorter than lambda");
  dac_output_a: assert property (sample_en |=> dac_strobe ##1 !dac_strobe) // R01
    else $error("sample not strobed once");
  index_step_a: assert property (sample_en // R02
    |=> idx_reg[0] == 16'($past(idx_reg[0]) + $past(delta_reg[0]))) else $error("index step wrong");
  acc_step_a: assert property (cyc_tick && sensor_active && $past(sensor_active) // R06
    |=> acc_reg[0] == 22'($past(acc_reg[0]) + $past(delta_reg[0]))) else $error("accumulator step wrong");
  dual_edge_a: assert property (cyc_tick && sensor_active && sensor_type == dual_edge_sensor_type // R08
    && half_cross[0] |-> edge_pulse[0]) else $error("dual edge pulse missing");
  trailing_edge_a: assert property (sensor_type == trailing_edge_sensor_type && !tooth_ovf[0] // R09
    |-> !edge_pulse[0]) else $error("trailing edge pulse outside overflow");
  expert_delta_a: assert property (cfg_load && !cfg_busy && freq_mode == MODE_EXPERT // R10
    |=> delta_reg == $past(wheel_value)) else $error("expert delta not taken");
  pwm_start_a: assert property (edge_pulse[0] |=> pwm_out[0]) // R15
    else $error("pwm pulse not started");
  decode_a: assert property (##1 board_selected == // R13
    ($past(bus_addr[ADDR_W-1:DECODE_LSB]) == $past(base_addr[ADDR_W-1:DECODE_LSB])))
    else $error("base decode wrong");
  cfg_done_a: assert property (cfg_load && !cfg_busy && freq_mode != MODE_EXPERT // R11 R12
    |=> cfg_busy [*8]) else $error("conversion ended early");

  passive_run_c: cover property (sample_en ##1 dac_strobe);
  active_tooth_c: cover property (edge_pulse[0] ##1 pwm_out[0]);
  convert_c: cover property ($fell(cfg_busy));
endmodule // wheel_sensor_signal_synth
`default_nettype wire

// file: bench/ecu_model.sv
// Receiving control unit model: times each PWM pulse of the four sensor lines
`timescale 1ns/1ps
`default_nettype none
module ecu_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Sensor lines
  input wire logic [3:0] pwm_in,
  // Measurements, valid for one cycle after each falling edge
  output logic [3:0] meas_valid,
  output logic [3:0][31:0] meas_width,
  output logic [3:0][31:0] meas_period
);
  logic [3:0][31:0] hi_cnt;
  logic [3:0][31:0] since_rise;
  logic [3:0] seen;
  logic [3:0] prev;
  // High time and rise spacing per line; the first pulse has no spacing
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      meas_valid[i] <= 1'b0;
      if (sys_rst) begin
        prev[i] <= 1'b0;
        seen[i] <= 1'b0;
        since_rise[i] <= '0;
        hi_cnt[i] <= '0;
      end else begin
        prev[i] <= pwm_in[i];
        since_rise[i] <= since_rise[i] + 32'h1;
        hi_cnt[i] <= hi_cnt[i] + 32'(pwm_in[i]);
        if (pwm_in[i] && !prev[i]) begin
          hi_cnt[i] <= 32'h1;
          since_rise[i] <= 32'h1;
          seen[i] <= 1'b1;
          meas_period[i] <= seen[i] ? since_rise[i] : '0;
        end
        if (!pwm_in[i] && prev[i]) begin
          meas_valid[i] <= 1'b1;
          meas_width[i] <= hi_cnt[i];
        end
      end
    end
  end
endmodule // ecu_model
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench of the wheel sensor signal synthesiser
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  import wss_pkg::*;
  localparam int TK = ACTIVE_CYCLE_CLKS;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  freq_mode_e freq_mode = MODE_EXPERT;
  logic sensor_active = 1'b0;
  sensor_type_e sensor_type = dual_edge_sensor_type;
  logic [SHIFT_W-1:0] sample_period_shift = 4'h1;
  logic [TEETH_W-1:0] teeth_count = 8'hff;
  logic cfg_load = 1'b0;
  logic cfg_busy;
  logic [CHANNELS-1:0][VALUE_W-1:0] wheel_value = '0;
  logic [CHANNELS-1:0][VALUE_W-1:0] wheel_radius = '0;
  logic [CHANNELS-1:0][DAC_W-1:0] amplitude = '0;
  logic [CHANNELS-1:0][PWM_W-1:0] hmax = '0;
  logic [CHANNELS-1:0][PWM_W-1:0] lmin = '0;
  logic [ADDR_W-1:0] bus_addr = '0;
  logic board_id_sel = 1'b0;
  logic board_selected;
  logic [CHANNELS-1:0][DAC_W-1:0] dac_code;
  logic dac_strobe;
  logic [CHANNELS-1:0] pwm_out;
  logic [3:0] meas_valid;
  logic [3:0][31:0] meas_width;
  logic [3:0][31:0] meas_period;
  logic [7:0] tops [4] = '{8'h58, 8'h05, 8'h05, 8'h58};
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  time last_t = 0;
  logic [CHANNELS-1:0][DAC_W-1:0] samp_q[$];
  logic [63:0] pulse_q[CHANNELS][$];
  logic [CHANNELS-1:0][DAC_W-1:0] samp_exp;
  logic [63:0] pulse_exp;

  wheel_sensor_signal_synth dut_u (.clk(clk), .sys_rst(sys_rst), .freq_mode(freq_mode),
    .sensor_active(sensor_active), .sensor_type(sensor_type), .sample_period_shift(sample_period_shift),
    .teeth_count(teeth_count), .cfg_load(cfg_load), .cfg_busy(cfg_busy), .wheel_value(wheel_value),
    .wheel_radius(wheel_radius), .amplitude(amplitude), .pwm_high_max_param(hmax), .pwm_low_min_param(lmin),
    .bus_addr(bus_addr), .board_id_sel(board_id_sel), .board_selected(board_selected), .dac_code(dac_code),
    .dac_strobe(dac_strobe), .pwm_out(pwm_out));
  ecu_model ecu_u (.clk(clk), .sys_rst(sys_rst), .pwm_in(pwm_out), .meas_valid(meas_valid),
    .meas_width(meas_width), .meas_period(meas_period));

  // Clock
  initial begin
    forever #5 clk = ~clk;
  end

  // Verdict and end of run
  task automatic end_of_test();
    if (num_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 99000) begin
      num_errors++;
      end_of_test();
    end
  end

  // Expected code at a quadrant point of the sine, scaled by amplitude
  function automatic logic [DAC_W-1:0] exp_code(input logic [15:0] idx, input logic [DAC_W-1:0] amp);
    logic signed [31:0] s;
    s = idx[14] ? 32'sd2047 : 32'sd0;
    s = idx[15] ? -s : s;
    s = (s * $signed({20'h0, amp})) >>> 12;
    return 12'(32'sd2048 + s);
  endfunction

  // Notes one expected pulse, given in ticks, as spacing and width in clocks
  task automatic exp_pulse(input int ch, input int per, input int hi);
    pulse_q[ch].push_back({32'(per * TK), 32'(hi * TK)});
  endtask

  // Short reset in mid-run
  task automatic rst_pulse();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  // One load pulse, then wait for the conversion to finish
  task automatic load_cfg(input logic busy_exp);
    int n;
    n = 0;
    @(posedge clk);
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
    #1;
    `CHK(cfg_busy, busy_exp)
    while (cfg_busy && n < 400) begin
      @(posedge clk);
      n++;
    end
    `CHK(n < 400, 1'b1)
  endtask

  // Wait until every noted result has been seen
  task automatic drain(input int lim);
    int n;
    n = 0;
    while ((samp_q.size() + pulse_q[0].size() + pulse_q[1].size() + pulse_q[2].size()
            + pulse_q[3].size()) > 0 && n < lim) begin
      @(posedge clk);
      n++;
    end
    `CHK(n < lim, 1'b1)
  endtask

  // Result watcher: oldest note against each sample and each pulse
  always @(posedge clk) begin
    if (dac_strobe) begin
      if (samp_q.size() > 0) begin
        samp_exp = samp_q.pop_front();
        `CHK(dac_code, samp_exp)
        if (last_t > 0) `CHK($time - last_t, 3 * PASSIVE_CYCLE_NS)
      end
      last_t = $time;
    end
    for (int i = 0; i < CHANNELS; i++) begin
      if (meas_valid[i]) begin
        pulse_exp = (pulse_q[i].size() > 0) ? pulse_q[i].pop_front() : 64'h0;
        `CHK({meas_period[i], meas_width[i]}, pulse_exp)
      end
    end
  end

  // Main sequence
  initial begin
    logic [7:0] tb;
    logic exp_sel;
    logic [CHANNELS-1:0][DAC_W-1:0] ex;
    int n;
    int h3;
    void'($urandom(32'hd655035f));
    for (int c = 0; c < CHANNELS; c++) begin
      wheel_value[c] <= {2'($urandom), 14'h0};
      amplitude[c] <= 12'($urandom);
    end
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK({dac_code, pwm_out, cfg_busy, board_selected}, {{CHANNELS{DAC_MID}}, 6'h0})
    // Board decode for both identifiers
    for (int i = 0; i < 8; i++) begin
      tb = (i < 4) ? tops[i] : 8'($urandom);
      exp_sel = (tb == (i[0] ? 8'h05 : 8'h58));
      @(posedge clk);
      board_id_sel <= i[0];
      bus_addr <= {tb, 16'($urandom)};
      @(posedge clk);
      #1;
      `CHK(board_selected, exp_sel)
    end
    // Passive sine in expert mode, three ticks per sample
    load_cfg(1'b0);
    for (int k = 0; k < 5; k++) begin
      for (int c = 0; c < CHANNELS; c++) ex[c] = exp_code(16'(k * wheel_value[c]), amplitude[c]);
      samp_q.push_back(ex);
    end
    drain(13000);
    // Active dual-edge sensor in frequency mode, saturated increment
    rst_pulse();
    freq_mode <= MODE_FREQ;
    sensor_active <= 1'b1;
    wheel_value <= {16'h0, 16'd15625, 16'd15625, 16'd15625};
    hmax <= {16'h0, 16'd29, 16'd29, 16'd3};
    lmin <= {16'h0, 16'd40, 16'd5, 16'd1};
    exp_pulse(0, 0, 4);
    exp_pulse(0, 32, 4);
    exp_pulse(1, 0, 30);
    exp_pulse(1, 32, 26);
    exp_pulse(2, 0, 30);
    exp_pulse(2, 32, 1);
    load_cfg(1'b1);
    `CHK(dac_code, {CHANNELS{DAC_MID}})
    drain(45000);
    // Active trailing-edge sensor in wheel speed mode
    rst_pulse();
    h3 = $urandom_range(15);
    freq_mode <= MODE_WHEEL;
    sensor_type <= trailing_edge_sensor_type;
    wheel_value <= {CHANNELS{16'hffff}};
    wheel_radius <= {16'h0, 16'h1, 16'h1, 16'h1};
    hmax <= {16'(h3), 16'd3, 16'd3, 16'd3};
    for (int c = 0; c < 3; c++) exp_pulse(c, 0, 4);
    exp_pulse(3, 0, h3 + 1);
    load_cfg(1'b1);
    n = 0;
    while (!pwm_out[0] && n < 31000) begin
      @(posedge clk);
      n++;
    end
    `CHK(n > 50 * TK && n < 31000, 1'b1)
    drain(10000);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
